// *** core/usr_cfg.svh ***
// constants for the eight-bit universal shift register core
`ifndef USR_CFG_SVH
`define USR_CFG_SVH

// ----------------------------------------------------------------------
// storage geometry
// ----------------------------------------------------------------------
`define USR_WIDTH         8
`define USR_MSB           7
`define USR_LSB           0
`define USR_WORD_RST      8'h00

// ----------------------------------------------------------------------
// apb map (byte addresses)
// ----------------------------------------------------------------------
`define USR_ADDR_W        12
`define USR_OFF_CTRL      12'h000
`define USR_OFF_STEP      12'h004
`define USR_OFF_DATA      12'h008
`define USR_OFF_STAT      12'h00c

// ctrl register fields
`define USR_CTRL_OWN      0
`define USR_CTRL_CLR_N    1
`define USR_CTRL_SEL_LO   2
`define USR_CTRL_SEL_HI   3
`define USR_CTRL_SER_R    4
`define USR_CTRL_SER_L    5
`define USR_CTRL_W        6
`define USR_CTRL_RST      6'h02

// status register fields
`define USR_STAT_DRIVE    0
`define USR_STAT_OWN      1
`define USR_STAT_MODE_LO  2
`define USR_STAT_MODE_HI  3

// ----------------------------------------------------------------------
// synchroniser reset image: clear active, disables low so pins driven
// ----------------------------------------------------------------------
`define USR_SYNC_RST      16'h0680

`endif

// *** core/usr_pkg.sv ***
// types shared by the universal shift register core
package usr_pkg;
    `include "usr_cfg.svh"

    typedef enum logic [1:0] {
        USR_HOLD  = 2'b00,
        USR_SHR   = 2'b01,
        USR_SHL   = 2'b10,
        USR_LOAD  = 2'b11
    } usr_mode_t;

    // pin image, one bit per sampled pin; order fixes the reset image
    typedef struct packed {
        logic       clk_pin;
        logic       clear_n;
        logic       dis_a;
        logic       dis_b;
        logic       sel_hi;
        logic       sel_lo;
        logic       ser_r;
        logic       ser_l;
        logic [7:0] bus;
    } usr_pins_t;

    typedef struct packed {
        logic       clear_n;
        usr_mode_t  mode;
        logic       ser_r;
        logic       ser_l;
    } usr_op_t;
endpackage

// *** core/usr_shift_reg.sv ***
// eight-bit universal shift/storage register with apb view
module usr_shift_reg
    import usr_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    ce,
    // device pins
    input  wire logic                    clock_pulse,
    input  wire logic                    sync_clear_n,
    input  wire logic                    mode_sel_lo,
    input  wire logic                    mode_sel_hi,
    input  wire logic                    serial_in_right,
    input  wire logic                    serial_in_left,
    input  wire logic                    out_disable_a,
    input  wire logic                    out_disable_b,
    input  wire logic [`USR_MSB:0]       parallel_bus_pins_i,
    output logic      [`USR_MSB:0]       parallel_bus_pins_o,
    output logic      [`USR_MSB:0]       parallel_bus_pins_oe,
    output logic                         serial_out_low,
    output logic                         serial_out_high,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`USR_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] usr_decode(
        input logic [`USR_ADDR_W-1:0] a
    );
        logic [3:0] hit;
        hit    = 4'h0;
        hit[0] = (a == `USR_OFF_CTRL);
        hit[1] = (a == `USR_OFF_STEP);
        hit[2] = (a == `USR_OFF_DATA);
        hit[3] = (a == `USR_OFF_STAT);
        return hit;
    endfunction

    // next word for one operation; interstage logic per bit
    function automatic logic [`USR_MSB:0] usr_next_word(
        input usr_op_t               op,
        input logic [`USR_MSB:0]     cur,
        input logic [`USR_MSB:0]     pins
    );
        logic [`USR_MSB:0] nw;
        nw = cur;
        if (!op.clear_n) begin
            nw = `USR_WORD_RST;
        end else begin
            unique case (op.mode)
                USR_HOLD: nw = cur;
                USR_SHR: begin
                    nw = {cur[`USR_MSB-1:0], op.ser_r};
                end
                USR_SHL: begin
                    nw = {op.ser_l, cur[`USR_MSB:1]};
                end
                USR_LOAD: nw = pins;
            endcase
        end
        return nw;
    endfunction

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    // clock_pulse is just another pin here; its edge is found after the
    // second stage, so device edges cost three clk cycles of latency and
    // clock_pulse must stay below half of clk for no edge to be lost
    usr_pins_t  pins_raw;
    usr_pins_t  meta_r;
    usr_pins_t  meta_nxt;
    usr_pins_t  sync_r;
    usr_pins_t  sync_nxt;
    logic       clk_dly_r;
    logic       clk_dly_nxt;

    always_comb begin
        pins_raw.clk_pin = clock_pulse;
        pins_raw.clear_n = sync_clear_n;
        pins_raw.dis_a   = out_disable_a;
        pins_raw.dis_b   = out_disable_b;
        pins_raw.sel_hi  = mode_sel_hi;
        pins_raw.sel_lo  = mode_sel_lo;
        pins_raw.ser_r   = serial_in_right;
        pins_raw.ser_l   = serial_in_left;
        pins_raw.bus     = parallel_bus_pins_i;
        meta_nxt         = pins_raw;
        sync_nxt         = meta_r;
        clk_dly_nxt      = sync_r.clk_pin;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r    <= usr_pins_t'(`USR_SYNC_RST);
            sync_r    <= usr_pins_t'(`USR_SYNC_RST);
            clk_dly_r <= 1'b0;
        end else if (ce) begin
            meta_r    <= meta_nxt;
            sync_r    <= sync_nxt;
            clk_dly_r <= clk_dly_nxt;
        end
    end

    // ------------------------------------------------------------------
    // apb control registers
    // ------------------------------------------------------------------
    logic [`USR_CTRL_W-1:0]  ctrl_r;
    logic [`USR_CTRL_W-1:0]  ctrl_nxt;
    logic                    step_r;
    logic                    step_nxt;
    logic [31:0]             prdata_r;
    logic [31:0]             prdata_nxt;
    logic                    pslverr_r;
    logic                    pslverr_nxt;
    logic [3:0]              hit;
    logic                    setup;
    logic                    wr_fire;
    logic [`USR_MSB:0]       q_r;
    logic [`USR_MSB:0]       q_nxt;
    logic                    drive_en;
    usr_op_t                 op_pin;
    usr_op_t                 op_sw;

    assign hit     = usr_decode(paddr);
    assign setup   = psel & ~penable;
    // zero wait states: every access phase completes at once
    assign pready  = 1'b1;
    assign wr_fire = psel & penable & pwrite;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    always_comb begin
        ctrl_nxt    = ctrl_r;
        step_nxt    = 1'b0;
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        if (wr_fire && hit[0]) begin
            ctrl_nxt = pwdata[`USR_CTRL_W-1:0];
        end
        // a step only means something while software owns the register
        if (wr_fire && hit[1]) begin
            step_nxt = ctrl_r[`USR_CTRL_OWN];
        end
        if (setup) begin
            pslverr_nxt = ~(|hit) | (pwrite & (hit[2] | hit[3]));
            prdata_nxt  = 32'h0000_0000;
            if (!pwrite) begin
                unique case (1'b1)
                    hit[0]: prdata_nxt[`USR_CTRL_W-1:0] = ctrl_r;
                    hit[2]: prdata_nxt[`USR_MSB:0]      = q_r;
                    hit[3]: begin
                        prdata_nxt[`USR_STAT_DRIVE] = drive_en;
                        prdata_nxt[`USR_STAT_OWN]   =
                            ctrl_r[`USR_CTRL_OWN];
                        prdata_nxt[`USR_STAT_MODE_HI:`USR_STAT_MODE_LO] =
                            op_pin.mode;
                    end
                    default: prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r    <= `USR_CTRL_RST;
            step_r    <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            ctrl_r    <= ctrl_nxt;
            step_r    <= step_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic pin_edge;

    assign pin_edge = sync_r.clk_pin & ~clk_dly_r;

    always_comb begin
        op_pin.clear_n = sync_r.clear_n;
        op_pin.mode    = usr_mode_t'({sync_r.sel_hi, sync_r.sel_lo});
        op_pin.ser_r   = sync_r.ser_r;
        op_pin.ser_l   = sync_r.ser_l;
        op_sw.clear_n  = ctrl_r[`USR_CTRL_CLR_N];
        op_sw.mode     = usr_mode_t'({ctrl_r[`USR_CTRL_SEL_HI],
                                      ctrl_r[`USR_CTRL_SEL_LO]});
        op_sw.ser_r    = ctrl_r[`USR_CTRL_SER_R];
        op_sw.ser_l    = ctrl_r[`USR_CTRL_SER_L];
    end

    // the word changes only at a rising pin edge, or a step when owned;
    // disables are not looked at, so ops run with pins released
    always_comb begin
        q_nxt = q_r;
        if (ctrl_r[`USR_CTRL_OWN]) begin
            if (step_r) begin
                q_nxt = usr_next_word(op_sw, q_r, sync_r.bus);
            end
        end else if (pin_edge) begin
            q_nxt = usr_next_word(op_pin, q_r, sync_r.bus);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q_r <= `USR_WORD_RST;
        end else if (ce) begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    // no clock in this path; the pin levels used are the synchronised ones
    assign drive_en = ~sync_r.dis_a & ~sync_r.dis_b
                    & ~(sync_r.sel_hi & sync_r.sel_lo);

    genvar gi;
    generate
        for (gi = 0; gi < `USR_WIDTH; gi = gi + 1) begin : g_drv
            assign parallel_bus_pins_o[gi]  = q_r[gi];
            assign parallel_bus_pins_oe[gi] = drive_en;
        end
    endgenerate

    // end bits for cascading, never released
    assign serial_out_low  = q_r[`USR_LSB];
    assign serial_out_high = q_r[`USR_MSB];

endmodule

// *** bench/usr_shift_reg_checker.sv ***
// port assertions for the universal shift register
module usr_shift_reg_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        ce,
    input wire logic        clock_pulse,
    input wire logic        sync_clear_n,
    input wire logic        mode_sel_lo,
    input wire logic        mode_sel_hi,
    input wire logic        out_disable_a,
    input wire logic        out_disable_b,
    input wire logic [7:0]  parallel_bus_pins_o,
    input wire logic [7:0]  parallel_bus_pins_oe,
    input wire logic        serial_out_low,
    input wire logic        serial_out_high,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset || !ce);
    // four samples cover the two-stage pin synchroniser
    property p_oe_off;
        (out_disable_a || out_disable_b) [*4] |-> parallel_bus_pins_oe == 8'h00;
    endproperty
    property p_oe_load;
        (mode_sel_hi && mode_sel_lo) [*4] |-> parallel_bus_pins_oe == 8'h00;
    endproperty
    property p_oe_on;
        (!out_disable_a && !out_disable_b && !(mode_sel_hi && mode_sel_lo)) [*4]
            |-> parallel_bus_pins_oe == 8'hff;
    endproperty
    property p_ser_low;
        serial_out_low == parallel_bus_pins_o[0];
    endproperty
    property p_ser_high;
        serial_out_high == parallel_bus_pins_o[7];
    endproperty
    property p_hold;
        !clock_pulse [*5] |-> $stable(parallel_bus_pins_o);
    endproperty
    property p_clear;
        !sync_clear_n && !clock_pulse ##1 (!sync_clear_n && clock_pulse) [*3]
            |-> ##[1:3] parallel_bus_pins_o == 8'h00;
    endproperty
    property p_apb_rdy;
        psel && penable |-> pready;
    endproperty
    property p_unmapped;
        psel && !penable && paddr > 12'h00c ##1 psel && penable |-> pslverr;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("pins driven while disabled");
    a_oe_load: assert property (p_oe_load)
        else $error("pins driven in load mode");
    a_oe_on: assert property (p_oe_on)
        else $error("pins not driven while enabled");
    a_ser_low: assert property (p_ser_low)
        else $error("low serial output differs from bit zero");
    a_ser_high: assert property (p_ser_high)
        else $error("high serial output differs from bit seven");
    a_hold: assert property (p_hold)
        else $error("word changed without a clock rise");
    a_clear: assert property (p_clear)
        else $error("clear did not zero the word");
    a_apb_rdy: assert property (p_apb_rdy)
        else $error("access phase without ready");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access without error");
    c_load: cover property (mode_sel_hi && mode_sel_lo && clock_pulse);
    c_clear: cover property (!sync_clear_n && clock_pulse);
    c_err: cover property (psel && penable && pslverr);
endmodule

// *** bench/usr_bus_agent.sv ***
// far-side master on the shared parallel bus
module usr_bus_agent (
    input wire logic       clk,
    input wire logic [7:0] oe,
    input wire logic [7:0] pins_o,
    input wire logic       drv_en,
    input wire logic [7:0] drv_data,
    output logic     [7:0] wire_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // no pull on the bus: a floating wire shows a moving pattern
    logic [7:0] junk = 8'h5a;
    always_ff @(posedge clk) junk <= ~junk;
    // agent drives only once the register has let go
    assign wire_lvl = oe[0] ? pins_o : (drv_en ? drv_data : junk);
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the universal shift register
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset = 1, ce = 1, clock_pulse = 0, sync_clear_n = 1;
    logic mode_sel_lo = 0, mode_sel_hi = 0, serial_in_right = 0;
    logic serial_in_left = 0, out_disable_a = 1, out_disable_b = 1;
    logic psel = 0, penable = 0, pwrite = 0, drv_en = 0, chk_now = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, r;
    logic [7:0]  parallel_bus_pins_i, parallel_bus_pins_o;
    logic [7:0]  parallel_bus_pins_oe, drv_data = 8'h00, q_exp = 8'h00;
    logic serial_out_low, serial_out_high, pready, pslverr;
    logic [31:0] prdata;
    logic [15:0] pin_q[$], pe;
    logic [33:0] apb_q[$], ae;
    int fails = 0, total_checks = 0;
    initial forever #10 clk = ~clk;
    usr_shift_reg DUT (.clk, .reset, .ce, .clock_pulse, .sync_clear_n,
        .mode_sel_lo, .mode_sel_hi, .serial_in_right, .serial_in_left,
        .out_disable_a, .out_disable_b, .parallel_bus_pins_i,
        .parallel_bus_pins_o, .parallel_bus_pins_oe, .serial_out_low,
        .serial_out_high, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    usr_bus_agent u_agent (.clk, .oe(parallel_bus_pins_oe),
        .pins_o(parallel_bus_pins_o), .drv_en, .drv_data,
        .wire_lvl(parallel_bus_pins_i));
    // ------------------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------------------
    task automatic bad(input logic [31:0] g, e);
        fails++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
    endtask
    task automatic chk_pin(input logic [7:0] g, e);
        total_checks++;
        if (g !== e) bad({24'h0, g}, {24'h0, e});
    endtask
    task automatic chk_apb(input logic [31:0] g, e);
        total_checks++;
        if (g !== e) bad(g, e);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    // pins settle 3 cycles ahead so the synchroniser sees them first
    task automatic op(input logic c, h, l, sr, sl, da, db,
                      input logic [7:0] d);
        sync_clear_n <= c;
        mode_sel_hi <= h;
        mode_sel_lo <= l;
        serial_in_right <= sr;
        serial_in_left <= sl;
        out_disable_a <= da;
        out_disable_b <= db;
        drv_data <= d;
        drv_en <= 1'b1;
        repeat (3) @(posedge clk);
        clock_pulse <= 1'b1;
        repeat (3) @(posedge clk);
        clock_pulse <= 1'b0;
        repeat (3) @(posedge clk);
        if (!c) q_exp = 8'h00;
        else if (h && l) q_exp = d;
        else if (l) q_exp = {q_exp[6:0], sr};
        else if (h) q_exp = {sl, q_exp[7:1]};
        pin_q.push_back({q_exp, (da || db || (h && l)) ? 8'h00 : 8'hff});
        chk_now <= 1'b1;
        @(posedge clk);
        chk_now <= 1'b0;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, e, input logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        apb_q.push_back({w, err, e});
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (chk_now) begin
            pe = pin_q.pop_front();
            chk_pin(parallel_bus_pins_o, pe[15:8]);
            chk_pin(parallel_bus_pins_oe, pe[7:0]);
            chk_pin({6'h0, serial_out_high, serial_out_low},
                    {6'h0, pe[15], pe[8]});
        end
        if (psel && penable && pready) begin
            ae = apb_q.pop_front();
            chk_apb({31'h0, pslverr}, {31'h0, ae[32]});
            if (!ae[33]) chk_apb(prdata, ae[31:0]);
        end
    end
    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        finish_test;
    end
    initial begin
        void'($urandom(32'ha50cc56e));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        apb(1'b0, 12'h000, 32'h0, 32'h2, 1'b0);
        apb(1'b0, 12'h040, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h008, 32'h5, 32'h0, 1'b1);
        op(1, 1, 1, 0, 0, 0, 0, 8'ha5);
        op(0, 1, 1, 1, 1, 0, 0, 8'hff);
        op(1, 0, 1, 1, 0, 1, 0, 8'h00);
        op(1, 1, 0, 0, 1, 0, 1, 8'h00);
        op(1, 0, 0, 1, 1, 0, 0, 8'h3c);
        for (int i = 0; i < 60; i++) begin
            r = $urandom;
            op(r[2:0] != 3'h0, r[3], r[4], r[5], r[6], r[9:8] == 2'h0,
               r[11:10] == 2'h0, r[19:12]);
        end
        apb(1'b0, 12'h008, 32'h0, {24'h0, q_exp}, 1'b0);
        repeat (2) @(posedge clk);
        finish_test;
    end
endmodule
bind usr_shift_reg usr_shift_reg_checker u_chk (.clk, .reset, .ce,
    .clock_pulse, .sync_clear_n, .mode_sel_lo, .mode_sel_hi,
    .out_disable_a, .out_disable_b, .parallel_bus_pins_o,
    .parallel_bus_pins_oe, .serial_out_low, .serial_out_high, .psel,
    .penable, .paddr, .pready, .pslverr);
